// file: hdl/host_bus_autodetect_port.sv
`timescale 1ns/10ps
`include "host_port_consts.svh"

// Overview of operation
// RULE_01: Eight-bit data, address and control buses.
// RULE_02: Detect strobe style; default separate strobes.
// RULE_03: Host writes once before first access.
// RULE_04: Detected settings hold until hardware reset.
// RULE_05: Lowest address line activity means non-multiplexed.
// RULE_06: Host writes then reads odd location first.
// RULE_07: Chip select with read freezes detection.
// RULE_08: Registers direct; RAM via pointer, data register.
// RULE_09: No wait states, no ready handshake.
// RULE_10: Pointer auto-increments or allows random access.
// RULE_11: Pointer low write fetches; data read doesn't (code: auto-increment read-direction data read fetches next byte).
// RULE_12: Write holds byte, then stores to RAM.
// RULE_13: Pointer load for read prefetches immediately.
// RULE_14: Diagnostic read clears; shared read pulse.
// RULE_15: Fast mode samples select, address on delay.
// RULE_16: Read pulse from second delay, ends undelayed.
// RULE_17: Read data uses live address, strobe.
// RULE_18: Read pulse clears diagnostic, starts RAM arbitration.
// RULE_19: Delays about 15 ns, then 10 ns.
// RULE_20: Host lengthens read strobe in fast mode.
// RULE_21: Timing bit: 0 normal, 1 fast read.
// RULE_22: Same scheme for direction plus strobe style.
module host_bus_autodetect_port (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic chip_select_low,
    input wire logic read_strobe_low,
    input wire logic write_strobe_low,
    input wire logic address_latch_enable,
    input wire logic [2:0] register_select_lines,
    input wire host_port_pkg::byte_t host_data_in,
    input wire host_port_pkg::byte_t next_id,
    input wire host_port_pkg::byte_t diagnostic_status_reg_event,
    input wire logic ram_grant,
    output host_port_pkg::byte_t host_data_out_q,
    output logic host_data_oe_q,
    output logic ram_arb_start_q,
    output logic write_buffer_ready_q,
    output logic style_is_dir_q,
    output logic bus_nonmux_q,
    output logic modes_frozen_q
);
    import host_port_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [14:0] pin_m_q, pin_s_q;
    wire [14:0] pin_raw = {chip_select_low, read_strobe_low,
        write_strobe_low, address_latch_enable, register_select_lines,
        host_data_in};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_m_q <= 15'h7000;
            pin_s_q <= 15'h7000;
        end else begin
            pin_m_q <= pin_raw;
            pin_s_q <= pin_m_q;
        end
    end

    wire cs_s = pin_s_q[14];
    wire rd_s = pin_s_q[13];
    wire wr_s = pin_s_q[12];
    wire ale_s = pin_s_q[11];
    wire [2:0] addr_s = pin_s_q[10:8];
    wire [7:0] din_s = pin_s_q[7:0];

    // ************************************************************
    // Interface detection
    // ************************************************************
    strobe_style_t style_q;
    logic nonmux_q, frozen_q, a0_q;
    logic [2:0] fill_q; // No edge watch until synchroniser shows real pins
    logic rd_act, wr_act;
    // In the direction style the read pin carries the direction
    // (high reads) and the write pin carries data_strobe_low.
    wire data_strobe_low = wr_s;

    always_comb begin
        unique case (style_q)
            STYLE_SEPARATE: begin
                rd_act = ~rd_s;
                wr_act = ~wr_s;
            end
            STYLE_DIR_STROBE: begin
                rd_act = rd_s & ~data_strobe_low; // see RULE_22
                wr_act = ~rd_s & ~data_strobe_low;
            end
            default: begin
                rd_act = 1'b0;
                wr_act = 1'b0;
            end
        endcase
    end

    // Both pins low never happens with separate strobes
    wire dir_seen = ~rd_s & ~wr_s; // see RULE_02
    wire a0_moved = fill_q[2] && addr_s[0] != a0_q; // see RULE_05
    wire sel = ~cs_s;
    wire freeze_now = sel & rd_act; // see RULE_07

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            style_q <= STYLE_SEPARATE; // see RULE_02
            nonmux_q <= 1'b0; // see RULE_05
            frozen_q <= 1'b0;
            a0_q <= 1'b0;
            fill_q <= 3'h0;
        end else begin
            a0_q <= addr_s[0];
            fill_q <= {fill_q[1:0], 1'b1};
            if (!frozen_q) begin // see RULE_04
                frozen_q <= freeze_now;
                if (dir_seen)
                    style_q <= STYLE_DIR_STROBE;
                if (a0_moved)
                    nonmux_q <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Address path
    // ************************************************************
    logic [2:0] ale_addr_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            ale_addr_q <= 3'h0;
        else if (ale_s && !nonmux_q)
            ale_addr_q <= din_s[2:0];
    end
    wire [2:0] live_addr = nonmux_q ? addr_s : ale_addr_q;

    // ************************************************************
    // Read pulse generation
    // ************************************************************
    // Delays are cycle counts; the host must stretch its strobe by
    // about the total delay in fast mode or no pulse is produced.
    logic [`RD_DLY_TOTAL-1:0] rd_hist_q;
    logic [2:0] samp_addr_q, rd_addr_q;
    logic samp_cs_q, d1_q, int_rd_q, fast_q;
    wire rd_d1 = rd_hist_q[`RD_DLY1_CYC-1]; // see RULE_19
    wire rd_d2 = rd_hist_q[`RD_DLY_TOTAL-1]; // see RULE_19
    wire d1_rise = rd_d1 & ~d1_q;
    wire int_rd = fast_q ? (rd_d2 & rd_act & samp_cs_q) // see RULE_16
                         : (rd_act & sel);
    wire [2:0] int_addr = fast_q ? samp_addr_q : live_addr;
    wire rd_pulse = int_rd & ~int_rd_q; // see RULE_18
    // Clear and fetch act as the read ends, so read data stands
    wire rd_end = int_rd_q & ~int_rd; // see RULE_16

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_hist_q <= '0;
            d1_q <= 1'b0;
            int_rd_q <= 1'b0;
            rd_addr_q <= 3'h0;
        end else begin
            // Chain empties when the strobe ends: no tail reaches next read
            rd_hist_q <= {rd_hist_q[`RD_DLY_TOTAL-2:0], rd_act}
                & {`RD_DLY_TOTAL{rd_act}};
            d1_q <= rd_d1;
            int_rd_q <= int_rd;
            if (rd_pulse)
                rd_addr_q <= int_addr;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            samp_addr_q <= 3'h0;
            samp_cs_q <= 1'b0;
        end else if (d1_rise) begin // see RULE_15
            samp_addr_q <= live_addr;
            samp_cs_q <= sel;
        end
    end

    // ************************************************************
    // Write decode and registers
    // ************************************************************
    logic wr_act_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            wr_act_q <= 1'b0;
        else
            wr_act_q <= wr_act & sel;
    end
    // Writes always use normal timing
    wire wr_pulse = wr_act & sel & ~wr_act_q; // see RULE_21
    wire wr_hi = wr_pulse && live_addr == `REG_PTR_HI;
    wire wr_lo = wr_pulse && live_addr == `REG_PTR_LO;
    wire wr_data = wr_pulse && live_addr == `REG_DATA;
    wire wr_cfg = wr_pulse && live_addr == `REG_CONFIG;
    wire rd_diagnostic_status_reg = rd_end && rd_addr_q == `REG_DIAGNOSTIC_STATUS_REG; // see RULE_14
    wire rd_data = rd_end && rd_addr_q == `REG_DATA;

    logic [`RAM_AW-1:0] ptr_q;
    logic autoinc_q, rdir_q, fetch_q, push_q;
    byte_t data_q, diagnostic_status_reg_q;
    logic buf_room;
    wire rd_step = rd_data & autoinc_q & rdir_q; // see RULE_10
    wire push_ok = push_q & buf_room;
    wire ptr_step = rd_step | (push_ok & autoinc_q); // see RULE_10

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_q <= '0;
            autoinc_q <= 1'b0;
            rdir_q <= 1'b0;
            fast_q <= 1'b0; // see RULE_21
        end else begin
            if (wr_hi) begin
                autoinc_q <= din_s[`PTR_HI_AUTOINC];
                rdir_q <= din_s[`PTR_HI_READ];
                ptr_q[`RAM_AW-1:8] <= din_s[`RAM_AW-9:0];
            end else if (wr_lo) begin
                ptr_q[7:0] <= din_s;
            end else if (ptr_step) begin
                ptr_q <= ptr_q + 1'b1;
            end
            if (wr_cfg)
                fast_q <= din_s[`CFG_FAST_READ];
        end
    end

    // ************************************************************
    // RAM and data register
    // ************************************************************
    byte_t ram [0:(1<<`RAM_AW)-1];
    // A prefetch does not wait for buffered writes to drain; read
    // back a just-written byte only after the buffer empties.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_q <= 1'b0;
            push_q <= 1'b0;
            data_q <= 8'h00;
        end else begin
            fetch_q <= (wr_lo & rdir_q) | rd_step; // see RULE_13
            push_q <= wr_data & ~rdir_q;
            if (wr_data)
                data_q <= din_s; // see RULE_12
            else if (fetch_q)
                data_q <= ram[ptr_q]; // see RULE_11
        end
    end

    // ************************************************************
    // Two-entry write buffer
    // ************************************************************
    logic [`RAM_AW+7:0] buf_mem [0:1];
    logic [1:0] buf_cnt_q;
    logic buf_wp_q, buf_rp_q;
    assign buf_room = buf_cnt_q != `BUF_DEPTH;
    wire buf_out_valid = buf_cnt_q != 2'h0;
    wire pop = buf_out_valid & ram_grant;
    wire [1:0] buf_cnt_d = buf_cnt_q + {1'b0, push_ok} - {1'b0, pop};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            buf_cnt_q <= 2'h0;
            buf_wp_q <= 1'b0;
            buf_rp_q <= 1'b0;
        end else begin
            buf_cnt_q <= buf_cnt_d;
            if (push_ok)
                buf_wp_q <= ~buf_wp_q;
            if (pop)
                buf_rp_q <= ~buf_rp_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push_ok)
            buf_mem[buf_wp_q] <= {ptr_q, data_q}; // see RULE_12
        if (pop)
            ram[buf_mem[buf_rp_q][`RAM_AW+7:8]] <= buf_mem[buf_rp_q][7:0];
    end

    // ************************************************************
    // Diagnostic status
    // ************************************************************
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            diagnostic_status_reg_q <= 8'h00;
        else
            diagnostic_status_reg_q <= (diagnostic_status_reg_q & ~{8{rd_diagnostic_status_reg}}) | diagnostic_status_reg_event; // see RULE_14
    end

    // ************************************************************
    // Read data path
    // ************************************************************
    // Live address and undelayed strobe keep access time short
    byte_t rd_mux;
    always_comb begin
        case (live_addr) // see RULE_17
            `REG_STATUS: rd_mux = {5'h00, frozen_q, nonmux_q,
                                   style_q == STYLE_DIR_STROBE};
            `REG_DIAGNOSTIC_STATUS_REG: rd_mux = diagnostic_status_reg_q;
            `REG_PTR_HI: rd_mux = {autoinc_q, rdir_q, 3'h0,
                                   ptr_q[`RAM_AW-1:8]};
            `REG_PTR_LO: rd_mux = ptr_q[7:0];
            `REG_DATA: rd_mux = data_q; // see RULE_08
            `REG_NEXT_ID: rd_mux = next_id;
            `REG_CONFIG: rd_mux = {7'h00, fast_q};
            default: rd_mux = 8'h00;
        endcase
    end

    // ************************************************************
    // Output flops
    // ************************************************************
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            host_data_out_q <= 8'h00;
            host_data_oe_q <= 1'b0;
            ram_arb_start_q <= 1'b0;
            write_buffer_ready_q <= 1'b1;
            style_is_dir_q <= 1'b0;
            bus_nonmux_q <= 1'b0;
            modes_frozen_q <= 1'b0;
        end else begin
            host_data_out_q <= rd_mux; // see RULE_09
            host_data_oe_q <= rd_act & sel; // see RULE_01
            ram_arb_start_q <= rd_data; // see RULE_18
            write_buffer_ready_q <= buf_cnt_d != `BUF_DEPTH;
            style_is_dir_q <= style_q == STYLE_DIR_STROBE;
            bus_nonmux_q <= nonmux_q;
            modes_frozen_q <= frozen_q;
        end
    end

endmodule // host_bus_autodetect_port

// file: hdl/host_port_consts.svh
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

// ****************************************************************
// Register select codes
// ****************************************************************
`define REG_STATUS 3'h0
`define REG_DIAGNOSTIC_STATUS_REG 3'h1
`define REG_PTR_HI 3'h2
`define REG_PTR_LO 3'h3
`define REG_DATA 3'h4
`define REG_NEXT_ID 3'h5
`define REG_CONFIG 3'h6

// ****************************************************************
// Field positions
// ****************************************************************
`define PTR_HI_AUTOINC 7
`define PTR_HI_READ 6
`define CFG_FAST_READ 0
`define RAM_AW 11
`define BUF_DEPTH 2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 5
`define RD_DLY1_NS 15
`define RD_DLY2_NS 10
`define RD_DLY1_CYC ((`RD_DLY1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_DLY2_CYC ((`RD_DLY2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_DLY_TOTAL (`RD_DLY1_CYC + `RD_DLY2_CYC)

`endif

// file: hdl/host_port_pkg.sv
package host_port_pkg;

    // ************************************************************
    // Strobe style, one-hot
    // ************************************************************
    typedef enum logic [1:0] {
        STYLE_SEPARATE = 2'b01,
        STYLE_DIR_STROBE = 2'b10
    } strobe_style_t;

    typedef logic [7:0] byte_t;

endpackage

// file: dv/host_bus_autodetect_port_asserts.sv
`timescale 1ns/10ps
module host_bus_autodetect_port_asserts (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic chip_select_low,
    input wire logic read_strobe_low,
    input wire logic write_strobe_low,
    input wire logic [2:0] register_select_lines,
    input wire logic ram_grant,
    input wire logic host_data_oe_q,
    input wire logic ram_arb_start_q,
    input wire logic write_buffer_ready_q,
    input wire logic style_is_dir_q,
    input wire logic bus_nonmux_q,
    input wire logic modes_frozen_q
);
    import host_port_pkg::*;
    wire sep_rd = !chip_select_low && !read_strobe_low;
    wire lowest_a = register_select_lines[0];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_reset_values: assert property ($rose(arst_n) |-> !style_is_dir_q &&
        !bus_nonmux_q && !modes_frozen_q && write_buffer_ready_q)
        else $error("outputs not at reset values");
    a_style_sticky: assert property (style_is_dir_q |=> style_is_dir_q)
        else $error("strobe style left direction mode");
    a_nonmux_sticky: assert property (bus_nonmux_q |=> bus_nonmux_q)
        else $error("bus type left non-multiplexed");
    a_frozen_stable: assert property (modes_frozen_q |=>
        $stable(style_is_dir_q) && $stable(bus_nonmux_q))
        else $error("mode changed after freeze");
    a_freeze_on_read: assert property ((!style_is_dir_q && sep_rd &&
        write_strobe_low) [*3] |-> ##[0:3] modes_frozen_q)
        else $error("select with read did not freeze");
    a_dir_detect: assert property (chip_select_low && !read_strobe_low &&
        !write_strobe_low && !modes_frozen_q |-> ##[1:4] style_is_dir_q)
        else $error("both strobes low not seen");
    a_nonmux_detect: assert property (!modes_frozen_q && $changed(lowest_a)
        |-> ##[1:4] (bus_nonmux_q || modes_frozen_q))
        else $error("lowest address activity not seen");
    a_oe_from_read: assert property (host_data_oe_q && !style_is_dir_q
        |-> $past(sep_rd, 3))
        else $error("data driven without read");
    a_arb_one_cycle: assert property (ram_arb_start_q |=> !ram_arb_start_q)
        else $error("arbitration start longer than one cycle");
    a_ready_refill: assert property (!write_buffer_ready_q && ram_grant
        |-> ##[1:3] write_buffer_ready_q)
        else $error("buffer did not drain on grant");
endmodule // host_bus_autodetect_port_asserts

bind host_bus_autodetect_port host_bus_autodetect_port_asserts i_asserts (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .chip_select_low(chip_select_low),
    .read_strobe_low(read_strobe_low),
    .write_strobe_low(write_strobe_low),
    .register_select_lines(register_select_lines),
    .ram_grant(ram_grant),
    .host_data_oe_q(host_data_oe_q),
    .ram_arb_start_q(ram_arb_start_q),
    .write_buffer_ready_q(write_buffer_ready_q),
    .style_is_dir_q(style_is_dir_q),
    .bus_nonmux_q(bus_nonmux_q),
    .modes_frozen_q(modes_frozen_q)
);

// file: dv/host_cpu_model.sv
`timescale 1ns/10ps
module host_cpu_model (
    input wire logic sys_clk,
    output logic chip_select_low,
    output logic read_strobe_low,
    output logic write_strobe_low,
    output logic address_latch_enable,
    output logic [2:0] register_select_lines,
    output host_port_pkg::byte_t host_data_in,
    input wire host_port_pkg::byte_t host_data_out_q
);
    import host_port_pkg::*;
    bit dir;
    bit mux = 1'b1;
    initial begin
        chip_select_low = 1'b1;
        read_strobe_low = 1'b1;
        write_strobe_low = 1'b1;
        address_latch_enable = 1'b0;
        register_select_lines = 3'h0;
        host_data_in = 8'h00;
    end
    // ************************************************************
    // One access; strobes lead select so style shows before a read
    // ************************************************************
    task automatic access(input bit rd, input logic [2:0] a, input byte_t d,
                          input int len, output byte_t q);
        @(negedge sys_clk);
        if (mux) begin
            address_latch_enable <= 1'b1;
            host_data_in <= {5'h00, a};
            @(negedge sys_clk);
            address_latch_enable <= 1'b0;
        end else begin
            register_select_lines <= a;
        end
        host_data_in <= rd ? ~host_data_in : d;
        read_strobe_low <= dir ? rd : !rd;
        write_strobe_low <= dir ? 1'b0 : rd;
        @(negedge sys_clk);
        chip_select_low <= 1'b0;
        repeat (len) @(negedge sys_clk);
        q = host_data_out_q;
        chip_select_low <= 1'b1;
        read_strobe_low <= 1'b1;
        write_strobe_low <= 1'b1;
        register_select_lines <= 3'h0;
        host_data_in <= ~host_data_in;
        repeat (3) @(negedge sys_clk);
    endtask
endmodule // host_cpu_model

// file: dv/host_bus_autodetect_port_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e); \
    end \
end
module host_bus_autodetect_port_test;
    import host_port_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic ram_grant = 1'b0;
    byte_t next_id = 8'h5a;
    byte_t diagnostic_status_reg_event = 8'h00;
    byte_t q, din, dout;
    logic cs_n, rd_n, wr_n, ale, oe, arb, rdy, dir_q, nonmux_q, frozen_q;
    logic [2:0] sel;
    int n_fail, comparisons, cycles, n_arb;
    host_cpu_model i_cpu (.sys_clk(sys_clk), .chip_select_low(cs_n),
        .read_strobe_low(rd_n), .write_strobe_low(wr_n),
        .address_latch_enable(ale), .register_select_lines(sel),
        .host_data_in(din), .host_data_out_q(dout));
    host_bus_autodetect_port i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .chip_select_low(cs_n), .read_strobe_low(rd_n),
        .write_strobe_low(wr_n), .address_latch_enable(ale),
        .register_select_lines(sel), .host_data_in(din),
        .next_id(next_id), .diagnostic_status_reg_event(diagnostic_status_reg_event), .ram_grant(ram_grant),
        .host_data_out_q(dout), .host_data_oe_q(oe), .ram_arb_start_q(arb),
        .write_buffer_ready_q(rdy), .style_is_dir_q(dir_q),
        .bus_nonmux_q(nonmux_q), .modes_frozen_q(frozen_q));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ************************************************************
    // Hang guard, well above the few hundred cycles the run needs
    // ************************************************************
    always @(posedge sys_clk) begin
        cycles++;
        if (arb === 1'b1) n_arb++;
        if (cycles == 5000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input byte_t d);
        byte_t unused;
        i_cpu.access(1'b0, a, d, 4, unused);
    endtask
    task automatic rd(input logic [2:0] a, input int len = 10);
        i_cpu.access(1'b1, a, 8'h00, len, q);
    endtask
    task automatic do_reset(input bit dir, input bit mux);
        i_cpu.dir = dir;
        i_cpu.mux = mux;
        arst_n = 1'b0;
        repeat (5) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic pulse_diagnostic_status_reg(input byte_t v);
        @(negedge sys_clk);
        diagnostic_status_reg_event = v;
        @(negedge sys_clk);
        diagnostic_status_reg_event = 8'h00;
    endtask
    initial begin
        do_reset(1'b0, 1'b1);
        `CHK(dir_q, 1'b0);
        `CHK(nonmux_q, 1'b0);
        wr(3'h3, 8'h00);
        `CHK(frozen_q, 1'b0);
        rd(3'h5);
        `CHK(q, 8'h5a);
        `CHK(frozen_q, 1'b1);
        `CHK(nonmux_q, 1'b0);
        i_cpu.mux = 1'b0;
        rd(3'h5);
        i_cpu.dir = 1'b1;
        wr(3'h7, 8'h00);
        `CHK(nonmux_q, 1'b0);
        `CHK(dir_q, 1'b0);
        do_reset(1'b0, 1'b0);
        wr(3'h3, 8'h00);
        `CHK(nonmux_q, 1'b1);
        rd(3'h5);
        wr(3'h2, 8'h80);
        wr(3'h3, 8'h10);
        wr(3'h4, 8'haa);
        wr(3'h4, 8'h55);
        `CHK(rdy, 1'b0);
        wr(3'h4, 8'h77);
        ram_grant = 1'b1;
        repeat (4) @(negedge sys_clk);
        `CHK(rdy, 1'b1);
        wr(3'h2, 8'hc0);
        wr(3'h3, 8'h10);
        n_arb = 0;
        rd(3'h4);
        `CHK(q, 8'haa);
        rd(3'h4);
        `CHK(q, 8'h55);
        repeat (2) @(negedge sys_clk);
        `CHK(n_arb, 2);
        wr(3'h2, 8'h40);
        wr(3'h3, 8'h11);
        rd(3'h4);
        `CHK(q, 8'h55);
        rd(3'h4);
        `CHK(q, 8'h55);
        pulse_diagnostic_status_reg(8'h01);
        rd(3'h1);
        `CHK(q, 8'h01);
        rd(3'h1);
        `CHK(q, 8'h00);
        wr(3'h6, 8'h01);
        pulse_diagnostic_status_reg(8'h02);
        rd(3'h1, 3);
        rd(3'h1);
        `CHK(q, 8'h02);
        rd(3'h1);
        `CHK(q, 8'h00);
        rd(3'h0);
        `CHK(q, 8'h06);
        rd(3'h7);
        `CHK(q, 8'h00);
        do_reset(1'b1, 1'b0);
        wr(3'h3, 8'h00);
        `CHK(dir_q, 1'b1);
        rd(3'h5);
        `CHK(q, 8'h5a);
        `CHK(frozen_q, 1'b1);
        finish_test();
    end
endmodule // host_bus_autodetect_port_test
